//--- bench/mac_table_command_and_aging_bench.sv
// self-checking bench: apb commands, age scans and frame lookups against a key model
`timescale 1ns/1ps
module mac_table_command_and_aging_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        lrn_req, fwd_req, fwd_ipv4, fwd_ipv6, fwd_done, fwd_hit, fwd_embedded;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [47:0] lrn_smac, fwd_dmac, m, l, n;
	logic [12:0] lrn_vid, fwd_vid;
	logic [10:0] fwd_ports;
	logic [5:0]  fwd_ptr;
	logic [59:0] live[$]; // model: keys of records in use
	logic [60:0] b;       // model: search result, flag on top
	int          num_errors, cmp_count, cyc, seed;

	mac_table_command_and_aging mac_table_command_and_aging_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .lrn_req, .lrn_smac, .lrn_vid, .fwd_req, .fwd_dmac,
		.fwd_vid, .fwd_ipv4, .fwd_ipv6, .fwd_done, .fwd_hit, .fwd_embedded, .fwd_ports, .fwd_ptr);

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic final_report();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// load key, issue command, poll until idle; rd ends holding the command register
	task automatic op(input logic [47:0] mac, input logic [12:0] vid, input logic [31:0] c);
		int k;
		k = 0;
		apb(1'b1, 8'h00, mac[31:0]);
		apb(1'b1, 8'h04, {3'h0, vid, mac[47:32]});
		apb(1'b1, 8'h0C, c);
		// long scans must show their code while running
		if (c[2:0] inside {3'h3, 3'h6, 3'h7}) begin
			apb(1'b0, 8'h0C, 32'h0);
			chk(rd[2:0], c[2:0], "busy code");
		end
		do begin
			apb(1'b0, 8'h0C, 32'h0);
			k++;
		end while (rd[2:0] !== 3'h0 && k < 3000);
		chk(rd[2:0], 3'h0, "idle");
	endtask

	// frame lookup; port fields only judged on a hit
	task automatic fwd(input logic [47:0] d, input logic [12:0] v, input logic [1:0] ip, input logic [19:0] e);
		@(posedge pclk);
		fwd_req  <= 1'b1;
		fwd_dmac <= d;
		fwd_vid  <= v;
		{fwd_ipv4, fwd_ipv6} <= ip;
		@(posedge pclk);
		fwd_req  <= 1'b0;
		#1;
		chk({fwd_done, fwd_hit}, {1'b1, e[18]}, "fwd hit");
		if (e[18])
			chk({fwd_embedded, fwd_ports, fwd_ptr}, e[17:0], "fwd set");
	endtask

	// model: smallest live key above k
	function automatic logic [60:0] nxt(input logic [59:0] k);
		logic [60:0] r;
		r = {1'b0, {60{1'b1}}};
		foreach (live[i])
			if (live[i] > k && live[i] <= r[59:0])
				r = {1'b1, live[i]};
		return r;
	endfunction

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			$display("MISMATCH t=%0t timeout", $time);
			final_report();
		end
	end

	// main sequence
	initial begin
		seed = 70125;
		{presetn, psel, penable, pwrite, lrn_req, fwd_req, fwd_ipv4, fwd_ipv6} = 8'h00;
		{paddr, pwdata, lrn_smac, lrn_vid, fwd_dmac, fwd_vid} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h14, 32'h0);
		chk(err, 1'b1, "unmapped");
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0, "interval reset");
		chk(err, 1'b0, "mapped");
		m = {16'h0A00, 32'($random(seed))};
		l = {16'h0B00, 32'($random(seed))};
		n = {16'h0C00, 32'($random(seed))};
		op(m, 13'h0007, 32'h00050001);
		op(l, 13'h0009, 32'h00060011);
		live = '{{12'h007, m}, {12'h009, l}};
		fwd(m, 13'h0007, 2'b00, {2'b01, 1'b0, 11'h000, 6'h05});
		op(m, 13'h0007, 32'h0000000C);
		chk(rd, 32'h00050008, "lookup");
		op(m, 13'h0007, 32'h00000003);
		op(m, 13'h0007, 32'h0000000C);
		chk(rd, 32'h00050048, "stale set");
		// frame from the station clears its mark
		@(posedge pclk);
		lrn_req  <= 1'b1;
		lrn_smac <= m;
		lrn_vid  <= 13'h0007;
		@(posedge pclk);
		lrn_req  <= 1'b0;
		op(m, 13'h0007, 32'h0000000C);
		chk(rd, 32'h00050008, "refresh");
		repeat (2) op(m, 13'h0007, 32'h00000003);
		op(m, 13'h0007, 32'h0000000C);
		chk(rd[3], 1'b0, "aged out");
		live = live.find(x) with (x != {12'h007, m});
		op(l, 13'h0009, 32'h0000000C);
		chk(rd, 32'h00060058, "locked kept");
		op(n, 13'h0003, 32'h00000001);
		op(n, 13'h0003, 32'h00000002);
		op(n, 13'h0003, 32'h0000000C);
		chk(rd[3], 1'b0, "forgotten");
		// direct write at last row and bucket, then read back
		apb(1'b1, 8'h08, 32'h000303FF);
		op(48'h0D0E0F101112, 13'h0ABC, 32'h002A03DD);
		op(48'h0, 13'h0, 32'h00000004);
		chk(rd, 32'h002A03D8, "read cmd");
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0F101112, "read lo");
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0ABC0D0E, "read hi");
		op(48'h000308112233, 13'h000C, 32'h00000021);
		op(48'h030800112233, 13'h000C, 32'h00000031);
		live.push_back({12'hABC, 48'h0D0E0F101112});
		live.push_back({12'h00C, 48'h000308112233});
		live.push_back({12'h00C, 48'h030800112233});
		fwd(48'h01005E112233, 13'h000C, 2'b10, {2'b01, 1'b1, 11'h308, 6'h00});
		fwd(48'h01005E112234, 13'h000C, 2'b10, 20'h0);
		fwd(48'h333300112233, 13'h000C, 2'b01, {2'b01, 1'b1, 11'h308, 6'h00});
		fwd(48'h333300112233, 13'h000D, 2'b01, 20'h0);
		fwd(48'h01005E112233, 13'h000C, 2'b00, 20'h0);
		fwd(48'h343300112233, 13'h000C, 2'b01, 20'h0);
		// take two get-next steps through the table in key order, starting from the zero key
		b = '0;
		repeat (2) begin
			op(b[47:0], {1'b0, b[59:48]}, 32'h00000007);
			b = nxt(b[59:0]);
			chk(rd[3], b[60], "next found");
			apb(1'b0, 8'h00, 32'h0);
			chk(rd, b[31:0], "next key");
		end
		op(l, 13'h0009, 32'h00000006);
		op(l, 13'h0009, 32'h0000000C);
		chk(rd[3], 1'b0, "cleared");
		op(48'h0, 13'h0, 32'h0000000F);
		chk(rd[3], 1'b0, "empty search");
		apb(1'b1, 8'h10, 32'd20);
		repeat (40) @(posedge pclk);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd[2:0], 3'h3, "periodic scan");
		final_report();
	end
endmodule

//--- src/mac_table_cfg.svh
// constants for the station-address table: geometry, op codes, register map, field positions
`ifndef MAC_TABLE_CFG_SVH
`define MAC_TABLE_CFG_SVH

// geometry
`define MT_ROW_W        10
`define MT_BKT_W        2
`define MT_ROWS         1024
`define MT_BUCKETS      4
`define MT_PORTS        11
`define MT_KEY_VID_W    12

// table operation codes
`define MT_OP_IDLE      3'h0
`define MT_OP_LEARN     3'h1
`define MT_OP_DELETE_ENTRY_OP    3'h2
`define MT_OP_AGE       3'h3
`define MT_OP_READ      3'h4
`define MT_OP_WRITE     3'h5
`define MT_OP_INIT      3'h6
`define MT_OP_GET_NEXT  3'h7

// record classes
`define MT_CLS_NORMAL   2'h0
`define MT_CLS_LOCKED   2'h1
`define MT_CLS_IPV4     2'h2
`define MT_CLS_IPV6     2'h3

// multicast destination prefixes and embedded port set positions
`define MT_V4_PFX       24'h01005E
`define MT_V6_PFX       16'h3333
`define MT_V4_PORT_LSB  24
`define MT_V6_PORT_LSB  32

// register offsets (byte addresses)
`define MT_OFF_ADDR_LO  8'h00
`define MT_OFF_ADDR_HI  8'h04
`define MT_OFF_INDEX    8'h08
`define MT_OFF_CMD      8'h0C
`define MT_OFF_SCAN     8'h10

// field positions
`define MT_HI_VID_LSB   16
`define MT_IDX_BKT_LSB  16
`define MT_CMD_OP_LSB   0
`define MT_CMD_VAL_BIT  3
`define MT_CMD_CLS_LSB  4
`define MT_CMD_AGED_BIT 6
`define MT_CMD_CPU_BIT  7
`define MT_CMD_KILL_BIT 8
`define MT_CMD_IGN_BIT  9
`define MT_CMD_PTR_LSB  16

// reset values
`define MT_SCAN_RST     32'h00000000

`endif

//--- src/mac_table_command_and_aging.sv
// station-address table with apb command registers, age scans and frame-side lookups
`timescale 1ns/1ps
`include "mac_table_cfg.svh"

module mac_table_command_and_aging #(
	parameter int ROWS    = `MT_ROWS,
	parameter int BUCKETS = `MT_BUCKETS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// source-station refresh from the frame path
	input  wire logic        lrn_req,
	input  wire logic [47:0] lrn_smac,
	input  wire logic [12:0] lrn_vid,
	// destination lookup from the frame path
	input  wire logic        fwd_req,
	input  wire logic [47:0] fwd_dmac,
	input  wire logic [12:0] fwd_vid,
	input  wire logic        fwd_ipv4,
	input  wire logic        fwd_ipv6,
	output logic             fwd_done,
	output logic             fwd_hit,
	output logic             fwd_embedded,
	output logic [10:0]      fwd_ports,
	output logic [5:0]       fwd_ptr
);

	localparam int RW      = `MT_ROW_W;
	localparam int BW      = `MT_BKT_W;
	localparam int ENTRIES = ROWS * BUCKETS;
	localparam int IW      = RW + BW;

	// only the documented geometry fits the fixed hash and index layout
	if (ROWS != (1 << RW) || BUCKETS != (1 << BW)) begin : g_bad_geometry
		$error("table geometry must be 1024 rows of 4 buckets");
	end

	// fixed row hash over the low 24 address bits and the vlan, shared by every path
	function automatic logic [RW-1:0] row_hash(logic [47:0] mac, logic [12:0] vid);
		row_hash = mac[9:0] ^ mac[19:10] ^ {6'h00, mac[23:20]} ^ vid[9:0] ^ {7'h00, vid[12:10]};
	endfunction

	// exact key match on a live record
	function automatic logic key_hit(mac_table_pkg::entry_s e, logic [47:0] mac, logic [12:0] vid);
		key_hit = e.valid && (e.mac == mac) && (e.vid == vid);
	endfunction

	// 60-bit ordering key, vlan on top
	function automatic logic [59:0] key60(mac_table_pkg::entry_s e);
		key60 = {e.vid[`MT_KEY_VID_W-1:0], e.mac};
	endfunction

	// frame destination match, class decides the rule
	function automatic logic fwd_match(mac_table_pkg::entry_s e, logic [47:0] d, logic [12:0] vid,
			logic v4, logic v6);
		logic ok;
		ok = 1'b0;
		case (e.cls)
			`MT_CLS_IPV4: ok = v4 && d[47:24] == `MT_V4_PFX && d[23:0] == e.mac[23:0];
			`MT_CLS_IPV6: ok = v6 && d[47:32] == `MT_V6_PFX && d[31:0] == e.mac[31:0];
			default:      ok = d == e.mac;
		endcase
		fwd_match = e.valid && e.vid == vid && ok;
	endfunction

	// storage: flip-flops, 1024 rows x 4 buckets
	mac_table_pkg::entry_s tbl [ENTRIES];

	// software-visible state
	mac_table_pkg::entry_s reg_ent_r;     // address regs plus command fields
	logic [RW-1:0]         tidx_row_r;    // direct_index_reg row
	logic [BW-1:0]         tidx_bkt_r;    // direct_index_reg bucket
	logic [2:0]            op_r;          // table_operation_field
	logic [31:0]           scan_ivl_r;    // periodic_scan_interval, cycles, 0 = off
	mac_table_pkg::state_e st_r;          // command engine state
	logic [IW-1:0]         scan_idx_r;    // scan position
	mac_table_pkg::entry_s best_r;        // best successor so far
	logic                  best_f_r;      // best_r holds a candidate
	logic [31:0]           ivl_cnt_r;     // periodic scan timer
	logic                  age_pend_r;    // periodic scan waiting for idle

	// apb flops
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;

	// frame lookup flops
	logic        fwd_done_r;
	logic        fwd_hit_r;
	logic        fwd_embed_r;
	logic [10:0] fwd_ports_r;
	logic [5:0]  fwd_ptr_r;

	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign fwd_done     = fwd_done_r;
	assign fwd_hit      = fwd_hit_r;
	assign fwd_embedded = fwd_embed_r;
	assign fwd_ports    = fwd_ports_r;
	assign fwd_ptr      = fwd_ptr_r;

	// apb decode: pready comes one cycle into the access phase, the write lands at that edge
	logic acc;
	logic fire_wr;
	logic mapped;
	logic cmd_go;
	logic auto_go;
	assign acc     = psel && penable;
	assign fire_wr = acc && pready_r && pwrite;
	assign mapped  = paddr == `MT_OFF_ADDR_LO || paddr == `MT_OFF_ADDR_HI || paddr == `MT_OFF_INDEX
		|| paddr == `MT_OFF_CMD || paddr == `MT_OFF_SCAN;
	// a command starts only from idle and only with a non-idle code
	assign cmd_go  = fire_wr && paddr == `MT_OFF_CMD && st_r == mac_table_pkg::st_idle
		&& pwdata[`MT_CMD_OP_LSB +: 3] != `MT_OP_IDLE;
	// a pending periodic scan yields to a software command in the same cycle
	assign auto_go = age_pend_r && st_r == mac_table_pkg::st_idle && !cmd_go;

	// read data assembly
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h00000000;
		case (paddr)
			`MT_OFF_ADDR_LO: rdata = reg_ent_r.mac[31:0];
			`MT_OFF_ADDR_HI: begin
				rdata[15:0]                     = reg_ent_r.mac[47:32];
				rdata[`MT_HI_VID_LSB +: 13]     = reg_ent_r.vid;
			end
			`MT_OFF_INDEX: begin
				rdata[RW-1:0]                   = tidx_row_r;
				rdata[`MT_IDX_BKT_LSB +: BW]    = tidx_bkt_r;
			end
			`MT_OFF_CMD: begin
				rdata[`MT_CMD_OP_LSB +: 3]      = op_r; // idle code once ready
				rdata[`MT_CMD_VAL_BIT]          = reg_ent_r.valid;
				rdata[`MT_CMD_CLS_LSB +: 2]     = reg_ent_r.cls;
				rdata[`MT_CMD_AGED_BIT]         = reg_ent_r.aged;
				rdata[`MT_CMD_CPU_BIT]          = reg_ent_r.cpu_copy;
				rdata[`MT_CMD_KILL_BIT]         = reg_ent_r.src_kill;
				rdata[`MT_CMD_IGN_BIT]          = reg_ent_r.ignore_vlan;
				rdata[`MT_CMD_PTR_LSB +: 6]     = reg_ent_r.ptr;
			end
			`MT_OFF_SCAN: rdata = scan_ivl_r;
			default: rdata = 32'h00000000;
		endcase
	end

	// apb answer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= acc && !pready_r;
			pslverr_r <= acc && !pready_r && !mapped;
			prdata_r  <= (acc && !pready_r && !pwrite) ? rdata : 32'h00000000;
		end
	end

	// bucket search in the row hashed from the loaded key
	logic [RW-1:0] cmd_row;
	logic          hit_f, free_f;
	logic [BW-1:0] hit_b, free_b;
	always_comb begin
		cmd_row = row_hash(reg_ent_r.mac, reg_ent_r.vid);
		hit_f   = 1'b0;
		free_f  = 1'b0;
		hit_b   = '0;
		free_b  = '0;
		for (int b = 0; b < BUCKETS; b++) begin
			if (!hit_f && key_hit(tbl[{cmd_row, BW'(b)}], reg_ent_r.mac, reg_ent_r.vid)) begin
				hit_f = 1'b1;
				hit_b = BW'(b);
			end
			if (!free_f && !tbl[{cmd_row, BW'(b)}].valid) begin
				free_f = 1'b1;
				free_b = BW'(b);
			end
		end
	end

	// source refresh search: only classes 0 and 1 are ever refreshed
	logic [IW-1:0] lrn_idx;
	logic          lrn_hit;
	always_comb begin
		lrn_idx = '0;
		lrn_hit = 1'b0;
		for (int b = 0; b < BUCKETS; b++) begin
			if (!lrn_hit && lrn_req && key_hit(tbl[{row_hash(lrn_smac, lrn_vid), BW'(b)}], lrn_smac, lrn_vid)
					&& !tbl[{row_hash(lrn_smac, lrn_vid), BW'(b)}].cls[1]) begin
				lrn_hit = 1'b1;
				lrn_idx = {row_hash(lrn_smac, lrn_vid), BW'(b)};
			end
		end
	end

	// current scan record and successor candidate
	mac_table_pkg::entry_s cur;
	logic                  cand;
	logic                  age_del;
	assign cur     = tbl[scan_idx_r];
	assign cand    = op_r == `MT_OP_GET_NEXT && cur.valid && key60(cur) > key60(reg_ent_r)
		&& (!best_f_r || key60(cur) < key60(best_r));
	// a frame refreshing this very record in the same cycle saves it
	assign age_del = op_r == `MT_OP_AGE && cur.valid && cur.aged && cur.cls == `MT_CLS_NORMAL
		&& !(lrn_hit && lrn_idx == scan_idx_r);

	// table write port of the command engine
	logic                  tbl_we;
	logic [IW-1:0]         tbl_wi;
	mac_table_pkg::entry_s tbl_wd;
	always_comb begin
		tbl_we = 1'b0;
		tbl_wi = '0;
		tbl_wd = '0;
		case (st_r)
			mac_table_pkg::st_exec: begin
				case (op_r)
					`MT_OP_LEARN: begin
						// reuse the matching bucket, else the first free one; a full row drops it
						tbl_we       = hit_f || free_f;
						tbl_wi       = {cmd_row, hit_f ? hit_b : free_b};
						tbl_wd       = reg_ent_r;
						tbl_wd.valid = 1'b1;
					end
					`MT_OP_DELETE_ENTRY_OP: begin
						tbl_we = hit_f;
						tbl_wi = {cmd_row, hit_b};
					end
					`MT_OP_WRITE: begin
						// any field contents accepted, placement bypasses the hash
						tbl_we = 1'b1;
						tbl_wi = {tidx_row_r, tidx_bkt_r};
						tbl_wd = reg_ent_r;
					end
					default: tbl_we = 1'b0;
				endcase
			end
			mac_table_pkg::st_scan: begin
				tbl_wi = scan_idx_r;
				if (op_r == `MT_OP_INIT) begin
					tbl_we = 1'b1;
				end else if (age_del) begin
					tbl_we = 1'b1;
				end else if (op_r == `MT_OP_AGE && cur.valid && !cur.aged) begin
					tbl_we      = 1'b1;
					tbl_wd      = cur;
					tbl_wd.aged = 1'b1;
				end
			end
			default: tbl_we = 1'b0;
		endcase
	end

	// table storage; the frame refresh is written last so it beats a same-cycle stale mark
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ENTRIES; i++) begin
				tbl[i] <= '0;
			end
		end else begin
			if (tbl_we) begin
				tbl[tbl_wi] <= tbl_wd;
			end
			if (lrn_hit) begin
				tbl[lrn_idx].aged <= 1'b0;
			end
		end
	end

	// command engine and software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= mac_table_pkg::st_idle;
			op_r       <= `MT_OP_IDLE;
			reg_ent_r  <= '0;
			tidx_row_r <= '0;
			tidx_bkt_r <= '0;
			scan_idx_r <= '0;
			best_r     <= '0;
			best_f_r   <= 1'b0;
		end else begin
			case (st_r)
				mac_table_pkg::st_idle: begin
					// data registers take writes only while idle, so results are never torn
					if (fire_wr && paddr == `MT_OFF_ADDR_LO) begin
						reg_ent_r.mac[31:0] <= pwdata;
					end
					if (fire_wr && paddr == `MT_OFF_ADDR_HI) begin
						reg_ent_r.mac[47:32] <= pwdata[15:0];
						reg_ent_r.vid        <= pwdata[`MT_HI_VID_LSB +: 13];
					end
					if (fire_wr && paddr == `MT_OFF_INDEX) begin
						tidx_row_r <= pwdata[RW-1:0];
						tidx_bkt_r <= pwdata[`MT_IDX_BKT_LSB +: BW];
					end
					if (fire_wr && paddr == `MT_OFF_CMD) begin
						reg_ent_r.valid       <= pwdata[`MT_CMD_VAL_BIT];
						reg_ent_r.cls         <= pwdata[`MT_CMD_CLS_LSB +: 2];
						reg_ent_r.aged        <= pwdata[`MT_CMD_AGED_BIT];
						reg_ent_r.cpu_copy    <= pwdata[`MT_CMD_CPU_BIT];
						reg_ent_r.src_kill    <= pwdata[`MT_CMD_KILL_BIT];
						reg_ent_r.ignore_vlan <= pwdata[`MT_CMD_IGN_BIT];
						reg_ent_r.ptr         <= pwdata[`MT_CMD_PTR_LSB +: 6];
					end
					scan_idx_r <= '0;
					best_f_r   <= 1'b0;
					if (cmd_go) begin
						op_r <= pwdata[`MT_CMD_OP_LSB +: 3];
						case (pwdata[`MT_CMD_OP_LSB +: 3])
							`MT_OP_AGE, `MT_OP_INIT, `MT_OP_GET_NEXT: st_r <= mac_table_pkg::st_scan;
							default: st_r <= mac_table_pkg::st_exec;
						endcase
					end else if (auto_go) begin
						op_r <= `MT_OP_AGE;
						st_r <= mac_table_pkg::st_scan;
					end
				end
				mac_table_pkg::st_exec: begin
					if (op_r == `MT_OP_READ) begin
						if (!reg_ent_r.valid) begin
							reg_ent_r <= tbl[{tidx_row_r, tidx_bkt_r}];
						end else if (hit_f) begin
							reg_ent_r <= tbl[{cmd_row, hit_b}];
						end else begin
							reg_ent_r.valid <= 1'b0;
						end
					end
					op_r <= `MT_OP_IDLE;
					st_r <= mac_table_pkg::st_idle;
				end
				mac_table_pkg::st_scan: begin
					if (cand) begin
						best_r   <= cur;
						best_f_r <= 1'b1;
					end
					scan_idx_r <= scan_idx_r + 1'b1;
					if (scan_idx_r == IW'(ENTRIES - 1)) begin
						if (op_r == `MT_OP_GET_NEXT) begin
							if (cand) begin
								reg_ent_r <= cur;
							end else if (best_f_r) begin
								reg_ent_r <= best_r;
							end else begin
								reg_ent_r.valid <= 1'b0;
							end
						end
						op_r <= `MT_OP_IDLE;
						st_r <= mac_table_pkg::st_idle;
					end
				end
				default: st_r <= mac_table_pkg::st_idle;
			endcase
		end
	end

	// interval register and periodic scan timer; a pending scan survives a busy engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_ivl_r <= `MT_SCAN_RST;
			ivl_cnt_r  <= 32'h00000000;
			age_pend_r <= 1'b0;
		end else begin
			if (fire_wr && paddr == `MT_OFF_SCAN) begin
				scan_ivl_r <= pwdata;
			end
			if (scan_ivl_r == 32'h00000000 || ivl_cnt_r >= scan_ivl_r - 32'h00000001) begin
				ivl_cnt_r <= 32'h00000000;
			end else begin
				ivl_cnt_r <= ivl_cnt_r + 32'h00000001;
			end
			// a new expiry wins over the start that clears the pending mark
			age_pend_r <= (age_pend_r && !auto_go)
				|| (scan_ivl_r != 32'h00000000 && ivl_cnt_r >= scan_ivl_r - 32'h00000001);
		end
	end

	// frame destination lookup, answered one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_done_r  <= 1'b0;
			fwd_hit_r   <= 1'b0;
			fwd_embed_r <= 1'b0;
			fwd_ports_r <= '0;
			fwd_ptr_r   <= '0;
		end else begin
			fwd_done_r  <= fwd_req;
			fwd_hit_r   <= 1'b0;
			fwd_embed_r <= 1'b0;
			fwd_ports_r <= '0;
			fwd_ptr_r   <= '0;
			for (int b = BUCKETS - 1; b >= 0; b--) begin
				// lowest matching bucket written last, so it wins
				if (fwd_req && fwd_match(tbl[{row_hash(fwd_dmac, fwd_vid), BW'(b)}], fwd_dmac, fwd_vid,
						fwd_ipv4, fwd_ipv6)) begin
					fwd_hit_r   <= 1'b1;
					fwd_embed_r <= tbl[{row_hash(fwd_dmac, fwd_vid), BW'(b)}].cls[1];
					fwd_ptr_r   <= tbl[{row_hash(fwd_dmac, fwd_vid), BW'(b)}].ptr;
					case (tbl[{row_hash(fwd_dmac, fwd_vid), BW'(b)}].cls)
						`MT_CLS_IPV4: fwd_ports_r <= tbl[{row_hash(fwd_dmac, fwd_vid), BW'(b)}]
							.mac[`MT_V4_PORT_LSB +: `MT_PORTS];
						`MT_CLS_IPV6: fwd_ports_r <= tbl[{row_hash(fwd_dmac, fwd_vid), BW'(b)}]
							.mac[`MT_V6_PORT_LSB +: `MT_PORTS];
						default: fwd_ports_r <= '0;
					endcase
				end
			end
		end
	end

	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_BUSY_NOT_IDLE: assert property (st_r != mac_table_pkg::st_idle |-> op_r != `MT_OP_IDLE)
		else $error("operation field idle while engine busy");
	AST_SCAN_ENDS: assert property (st_r == mac_table_pkg::st_scan && scan_idx_r == IW'(ENTRIES - 1)
		|=> st_r == mac_table_pkg::st_idle && op_r == `MT_OP_IDLE)
		else $error("scan did not finish after last entry");
	AST_AGE_DELETE: assert property (st_r == mac_table_pkg::st_scan && age_del
		|=> !tbl[$past(scan_idx_r)].valid)
		else $error("stale normal entry survived age scan");
	AST_AGE_MARK: assert property (st_r == mac_table_pkg::st_scan && op_r == `MT_OP_AGE && cur.valid
		&& !cur.aged && !(lrn_hit && lrn_idx == scan_idx_r) |=> tbl[$past(scan_idx_r)].aged)
		else $error("age scan did not set stale mark");
	AST_REFRESH: assert property (lrn_hit |=> !tbl[$past(lrn_idx)].aged)
		else $error("frame did not clear stale mark");
	AST_INIT_CLEAR: assert property (st_r == mac_table_pkg::st_scan && op_r == `MT_OP_INIT
		|=> !tbl[$past(scan_idx_r)].valid)
		else $error("initialise left an entry valid");
	// a same-cycle frame refresh may clear the stale mark of the written record, so that case is left out
	AST_WRITE_PLACE: assert property (st_r == mac_table_pkg::st_exec && op_r == `MT_OP_WRITE
		&& !(lrn_hit && lrn_idx == {tidx_row_r, tidx_bkt_r})
		|=> tbl[{$past(tidx_row_r), $past(tidx_bkt_r)}] == $past(reg_ent_r))
		else $error("write command stored wrong entry");
	AST_CMD_START: assert property (cmd_go |=> st_r != mac_table_pkg::st_idle ##1 1'b1)
		else $error("command accepted without leaving idle");
	AST_AUTO_SCAN: assert property (age_pend_r && st_r == mac_table_pkg::st_idle
		|=> st_r == mac_table_pkg::st_scan || st_r == mac_table_pkg::st_exec)
		else $error("pending periodic scan not started");
	AST_V4_PREFIX: assert property (fwd_req && !fwd_ipv6 && fwd_dmac[47:24] != `MT_V4_PFX
		|=> !fwd_embed_r)
		else $error("embedded port set without ipv4 multicast prefix");
	AST_V6_PREFIX: assert property (fwd_req && fwd_ipv6 && !fwd_ipv4 && fwd_dmac[47:32] != `MT_V6_PFX
		|=> !fwd_embed_r)
		else $error("embedded port set without ipv6 multicast prefix");

	COV_AGE_DELETE: cover property (st_r == mac_table_pkg::st_scan && age_del);
	COV_LOOKUP_HIT: cover property (st_r == mac_table_pkg::st_exec && op_r == `MT_OP_READ && reg_ent_r.valid && hit_f);
	COV_FWD_EMBED: cover property (fwd_hit_r && fwd_embed_r);
	COV_AUTO_AGE: cover property (auto_go);

endmodule

//--- src/mac_table_pkg.sv
// types shared by the station-address table logic
package mac_table_pkg;

	// one table record
	typedef struct packed {
		logic        valid;       // record in use
		logic [47:0] mac;         // station address
		logic [12:0] vid;         // vlan identifier
		logic [5:0]  ptr;         // port_set_pointer
		logic [1:0]  cls;         // record class
		logic        aged;        // stale mark
		logic        cpu_copy;    // copy to cpu
		logic        src_kill;    // drop from this station
		logic        ignore_vlan; // skip vlan port mask
	} entry_s;

	// command engine states
	typedef enum logic [1:0] {
		st_idle,
		st_exec,
		st_scan
	} state_e;

endpackage
